// *** core/slcd_pkg.sv ***
package slcd_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CHARGE = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_RAM0 = 8'h10;
	localparam int NCOM = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] CDS_ALWAYS = 4'h0;
	localparam logic [3:0] CDS_NEVER = 4'h7;
	localparam int CDS_TOP = 3;
	localparam int CDS_SEL32 = 2;
	localparam int CKS_SYS = 3;
	localparam int SGS_GROUP_SHIFT = 2;

	typedef enum logic [1:0] {
		DUTY_STATIC,
		DUTY_HALF,
		DUTY_THIRD,
		DUTY_QUARTER
	} slcd_duty_t;

	typedef enum logic [1:0] {
		LVL_GND,
		LVL_LOW_MID,
		LVL_HIGH_MID,
		LVL_FULL
	} slcd_level_t;

	typedef struct packed {
		logic display_active;
		logic segment_expansion_enable;
		logic drive_supply_switch;
		logic drive_supply_select;
		logic waveform_type_select;
		logic [3:0] frame_clock_select_field;
		logic [3:0] segment_select_field;
		slcd_duty_t duty_select;
	} slcd_cfg_t;

	localparam int CFG_W = $bits(slcd_cfg_t);
	localparam slcd_cfg_t CFG_RST = '0;
	localparam logic [3:0] CDS_RST = 4'h0;

	typedef struct packed {
		logic [1:0] slot;
		logic polarity;
		logic halted;
		logic divider_connect;
	} slcd_status_t;

	localparam int STATUS_W = $bits(slcd_status_t);
endpackage

// *** core/slcd_level_map.sv ***
`timescale 1ns/10ps
module slcd_level_map (
	input wire slcd_pkg::slcd_duty_t duty_i,
	input wire logic is_seg_i,
	input wire logic data_i,
	input wire logic pol_i,
	output slcd_pkg::slcd_level_t level_o
);
	always_comb begin
		level_o = slcd_pkg::LVL_GND;
		if (is_seg_i) begin
			unique case (duty_i)
				slcd_pkg::DUTY_STATIC, slcd_pkg::DUTY_HALF: begin
					if (data_i) level_o = pol_i ? slcd_pkg::LVL_FULL : slcd_pkg::LVL_GND;
					else level_o = pol_i ? slcd_pkg::LVL_GND : slcd_pkg::LVL_FULL;
				end
				slcd_pkg::DUTY_THIRD, slcd_pkg::DUTY_QUARTER: begin
					if (data_i) level_o = pol_i ? slcd_pkg::LVL_FULL : slcd_pkg::LVL_GND;
					else level_o = pol_i ? slcd_pkg::LVL_LOW_MID : slcd_pkg::LVL_HIGH_MID;
				end
			endcase
		end else begin
			if (data_i) begin
				level_o = pol_i ? slcd_pkg::LVL_GND : slcd_pkg::LVL_FULL;
			end else if (duty_i == slcd_pkg::DUTY_HALF) begin
				// the two middle pins are tied together on the board in this mode
				level_o = slcd_pkg::LVL_LOW_MID;
			end else begin
				level_o = pol_i ? slcd_pkg::LVL_HIGH_MID : slcd_pkg::LVL_LOW_MID;
			end
		end
	end
endmodule

// *** core/slcd_drive_ctrl.sv ***
`timescale 1ns/10ps
module slcd_drive_ctrl #(
	parameter int NSEG = 32
) (
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	input wire logic SUB_CLK_I,
	input wire logic SUB_CLOCK_ONLY_I,
	input wire logic AXI_AWVALID_I,
	output logic AXI_AWREADY_O,
	input wire logic [7:0] AXI_AWADDR_I,
	input wire logic [2:0] AXI_AWPROT_I,
	input wire logic AXI_WVALID_I,
	output logic AXI_WREADY_O,
	input wire logic [31:0] AXI_WDATA_I,
	input wire logic [3:0] AXI_WSTRB_I,
	output logic AXI_BVALID_O,
	input wire logic AXI_BREADY_I,
	output logic [1:0] AXI_BRESP_O,
	input wire logic AXI_ARVALID_I,
	output logic AXI_ARREADY_O,
	input wire logic [7:0] AXI_ARADDR_I,
	input wire logic [2:0] AXI_ARPROT_I,
	output logic AXI_RVALID_O,
	input wire logic AXI_RREADY_I,
	output logic [31:0] AXI_RDATA_O,
	output logic [1:0] AXI_RRESP_O,
	output slcd_pkg::slcd_level_t [slcd_pkg::NCOM-1:0] COM_LEVEL_O,
	output slcd_pkg::slcd_level_t [NSEG-1:0] SEG_LEVEL_O,
	output logic [NSEG-1:0] SEG_EN_O,
	output logic POLARITY_O,
	output logic DIVIDER_CONNECT_O,
	output logic STEPUP_EN_O,
	output logic DRIVE_SUPPLY_ON_O
);
	typedef enum logic [2:0] {
		SEL_CTRL,
		SEL_CHARGE,
		SEL_STATUS,
		SEL_RAM,
		SEL_NONE
	} slcd_sel_t;

	typedef struct packed {
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		slcd_pkg::slcd_cfg_t cfg;
		logic [3:0] cds;
		slcd_pkg::slcd_duty_t sh_duty;
		logic [3:0] sh_sgs;
		logic sh_wave;
		logic sh_sgx;
		logic [slcd_pkg::NCOM-1:0][31:0] ram;
		logic sub_s1;
		logic sub_s2;
		logic sub_s3;
		logic only_s1;
		logic only_s2;
		logic [1:0] sub_div;
		logic [7:0] sys_div;
		logic [4:0] phase;
		logic [1:0] slot;
		logic pol;
		logic halted;
		logic live;
		slcd_pkg::slcd_duty_t lvl_duty;
		logic connect;
		logic stepup;
		logic supply_on;
		slcd_pkg::slcd_level_t [slcd_pkg::NCOM-1:0] com_lvl;
		slcd_pkg::slcd_level_t [NSEG-1:0] seg_lvl;
		logic [NSEG-1:0] seg_en;
	} slcd_state_t;

	slcd_state_t s_reg;
	slcd_state_t s_next;
	logic [slcd_pkg::NCOM-1:0] com_data;
	logic [NSEG-1:0] seg_data;
	slcd_pkg::slcd_level_t [slcd_pkg::NCOM-1:0] com_map;
	slcd_pkg::slcd_level_t [NSEG-1:0] seg_map;
	logic tick;
	logic halt;
	logic frame_end;
	logic boundary;

	function automatic slcd_sel_t reg_sel(input logic [7:0] addr);
		if (addr == slcd_pkg::ADDR_CTRL) return SEL_CTRL;
		if (addr == slcd_pkg::ADDR_CHARGE) return SEL_CHARGE;
		if (addr == slcd_pkg::ADDR_STATUS) return SEL_STATUS;
		if (addr[7:4] == slcd_pkg::ADDR_RAM0[7:4] && addr[1:0] == 2'h0) return SEL_RAM;
		return SEL_NONE;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) r[8*b +: 8] = wd[8*b +: 8];
		end
		return r;
	endfunction

	function automatic logic [7:0] div_mask(input logic [2:0] k);
		logic [8:0] m;
		m = (9'h002 << k) - 9'h001;
		return m[7:0];
	endfunction

	// charge pulse: connected share of a 32-step cycle
	function automatic logic charge_on(input logic [3:0] cds, input logic [4:0] ph);
		if (cds[slcd_pkg::CDS_TOP]) begin
			if (cds[slcd_pkg::CDS_SEL32]) return ph == 5'h00;
			return ph[4:1] == 4'h0;
		end
		if (cds == slcd_pkg::CDS_ALWAYS) return 1'b1;
		if (cds == slcd_pkg::CDS_NEVER) return 1'b0;
		return {1'b0, ph[4:2]} < cds;
	endfunction

	assign AXI_AWREADY_O = !s_reg.aw_have && !s_reg.bvalid;
	assign AXI_WREADY_O = !s_reg.w_have && !s_reg.bvalid;
	assign AXI_ARREADY_O = !s_reg.rvalid;
	assign AXI_BVALID_O = s_reg.bvalid;
	assign AXI_BRESP_O = s_reg.bresp;
	assign AXI_RVALID_O = s_reg.rvalid;
	assign AXI_RDATA_O = s_reg.rdata;
	assign AXI_RRESP_O = s_reg.rresp;
	assign COM_LEVEL_O = s_reg.com_lvl;
	assign SEG_LEVEL_O = s_reg.seg_lvl;
	assign SEG_EN_O = s_reg.seg_en;
	assign POLARITY_O = s_reg.pol;
	assign DIVIDER_CONNECT_O = s_reg.connect;
	assign STEPUP_EN_O = s_reg.stepup;
	assign DRIVE_SUPPLY_ON_O = s_reg.supply_on;

	// a system-clock option stops with the main oscillator, so halt rather than leave DC
	assign halt = !s_reg.cfg.display_active ||
		(s_reg.only_s2 && s_reg.cfg.frame_clock_select_field[slcd_pkg::CKS_SYS]);

	always_comb begin
		logic sub_tick;
		logic sys_tick;
		logic [3:0] cks;
		sub_tick = 1'b0;
		sys_tick = 1'b0;
		cks = s_reg.cfg.frame_clock_select_field;
		if (s_reg.sub_s2 && !s_reg.sub_s3) begin
			if (cks[1]) sub_tick = s_reg.sub_div == 2'h3;
			else if (cks[0]) sub_tick = s_reg.sub_div[0];
			else sub_tick = 1'b1;
		end
		sys_tick = (s_reg.sys_div & div_mask(cks[2:0])) == div_mask(cks[2:0]);
		tick = !halt && (cks[slcd_pkg::CKS_SYS] ? sys_tick : sub_tick);
	end

	// A waveform flips polarity every tick and steps the common every two ticks
	assign frame_end = s_reg.slot == 2'(s_reg.sh_duty) && (s_reg.sh_wave || s_reg.pol);
	assign boundary = halt || (tick && frame_end);

	always_comb begin
		for (int c = 0; c < slcd_pkg::NCOM; c++) begin
			com_data[c] = (s_reg.sh_duty == slcd_pkg::DUTY_STATIC) || (2'(c) == s_reg.slot);
		end
		for (int i = 0; i < NSEG; i++) begin
			// expansion reads the RAM word from the far end, as the serial stream leaves it
			seg_data[i] = s_reg.ram[s_reg.slot][s_reg.sh_sgx ? NSEG-1-i : i];
		end
	end

	generate
		for (genvar c = 0; c < slcd_pkg::NCOM; c++) begin : g_com
			slcd_level_map u_com (
				.duty_i(s_reg.sh_duty),
				.is_seg_i(1'b0),
				.data_i(com_data[c]),
				.pol_i(s_reg.pol),
				.level_o(com_map[c])
			);
		end
		for (genvar i = 0; i < NSEG; i++) begin : g_seg
			slcd_level_map u_seg (
				.duty_i(s_reg.sh_duty),
				.is_seg_i(1'b1),
				.data_i(seg_data[i]),
				.pol_i(s_reg.pol),
				.level_o(seg_map[i])
			);
		end
	endgenerate

	always_comb begin
		logic [31:0] wr;
		logic [31:0] rd;
		wr = '0;
		rd = '0;
		s_next = s_reg;
		s_next.sub_s1 = SUB_CLK_I;
		s_next.sub_s2 = s_reg.sub_s1;
		s_next.sub_s3 = s_reg.sub_s2;
		s_next.only_s1 = SUB_CLOCK_ONLY_I;
		s_next.only_s2 = s_reg.only_s1;
		if (s_reg.sub_s2 && !s_reg.sub_s3) s_next.sub_div = s_reg.sub_div + 2'h1;
		s_next.sys_div = s_reg.sys_div + 8'h01;

		if (AXI_AWVALID_I && AXI_AWREADY_O) begin
			s_next.aw_have = 1'b1;
			s_next.aw_addr = AXI_AWADDR_I;
		end
		if (AXI_WVALID_I && AXI_WREADY_O) begin
			s_next.w_have = 1'b1;
			s_next.w_data = AXI_WDATA_I;
			s_next.w_strb = AXI_WSTRB_I;
		end
		if (s_reg.aw_have && s_reg.w_have) begin
			s_next.aw_have = 1'b0;
			s_next.w_have = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = slcd_pkg::RESP_OKAY;
			unique case (reg_sel(s_reg.aw_addr))
				SEL_CTRL: begin
					wr = merge(32'(s_reg.cfg), s_reg.w_data, s_reg.w_strb);
					s_next.cfg = slcd_pkg::slcd_cfg_t'(wr[slcd_pkg::CFG_W-1:0]);
				end
				SEL_CHARGE: begin
					wr = merge(32'(s_reg.cds), s_reg.w_data, s_reg.w_strb);
					s_next.cds = wr[3:0];
				end
				SEL_RAM: begin
					s_next.ram[s_reg.aw_addr[3:2]] = merge(s_reg.ram[s_reg.aw_addr[3:2]],
						s_reg.w_data, s_reg.w_strb);
				end
				SEL_STATUS: ;
				SEL_NONE: s_next.bresp = slcd_pkg::RESP_SLVERR;
			endcase
		end
		if (s_reg.bvalid && AXI_BREADY_I) s_next.bvalid = 1'b0;

		if (AXI_ARVALID_I && AXI_ARREADY_O) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = slcd_pkg::RESP_OKAY;
			unique case (reg_sel(AXI_ARADDR_I))
				SEL_CTRL: rd = 32'(s_reg.cfg);
				SEL_CHARGE: rd = 32'(s_reg.cds);
				SEL_STATUS: rd = 32'({s_reg.slot, s_reg.pol, s_reg.halted, s_reg.connect});
				SEL_RAM: rd = s_reg.ram[AXI_ARADDR_I[3:2]];
				SEL_NONE: s_next.rresp = slcd_pkg::RESP_SLVERR;
			endcase
			s_next.rdata = rd;
		end else if (s_reg.rvalid && AXI_RREADY_I) begin
			s_next.rvalid = 1'b0;
		end

		s_next.stepup = s_reg.cfg.drive_supply_select;
		s_next.supply_on = s_reg.cfg.drive_supply_switch;
		s_next.phase = s_reg.phase + 5'h01;
		// the panel keeps being driven in both halves; only the divider is switched
		s_next.connect = charge_on(s_reg.cds, s_reg.phase);
		s_next.halted = halt;

		if (boundary) begin
			s_next.sh_duty = s_reg.cfg.duty_select;
			s_next.sh_sgs = s_reg.cfg.segment_select_field;
			s_next.sh_wave = s_reg.cfg.waveform_type_select;
			s_next.sh_sgx = s_reg.cfg.segment_expansion_enable;
		end

		if (halt) begin
			s_next.slot = 2'h0;
			s_next.pol = 1'b0;
			s_next.live = 1'b0;
			s_next.com_lvl = '{default: slcd_pkg::LVL_GND};
			s_next.seg_lvl = '{default: slcd_pkg::LVL_GND};
			s_next.seg_en = '0;
		end else if (tick) begin
			s_next.live = 1'b1;
			s_next.lvl_duty = s_reg.sh_duty;
			s_next.com_lvl = com_map;
			for (int i = 0; i < NSEG; i++) begin
				s_next.seg_en[i] = (i >> slcd_pkg::SGS_GROUP_SHIFT) <= int'(s_reg.sh_sgs);
				s_next.seg_lvl[i] = s_next.seg_en[i] ? seg_map[i] : slcd_pkg::LVL_GND;
			end
			if (s_reg.sh_wave) begin
				if (frame_end) begin
					s_next.slot = 2'h0;
					s_next.pol = !s_reg.pol;
				end else begin
					s_next.slot = s_reg.slot + 2'h1;
				end
			end else begin
				s_next.pol = !s_reg.pol;
				if (s_reg.pol) s_next.slot = frame_end ? 2'h0 : s_reg.slot + 2'h1;
			end
		end
	end

	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			s_reg <= '0;
			s_reg.cfg <= slcd_pkg::CFG_RST;
			s_reg.cds <= slcd_pkg::CDS_RST;
			s_reg.connect <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RST_B_I);

	sequence seq_write_pair;
		s_reg.aw_have && s_reg.w_have;
	endsequence

	sequence seq_resp_wait;
		AXI_BVALID_O && !AXI_BREADY_I;
	endsequence

	AST_WRITE_RESP: assert property (seq_write_pair |=> AXI_BVALID_O && !AXI_AWREADY_O)
		else $error("write not answered one cycle after address and data");
	AST_RESP_HOLD: assert property (seq_resp_wait |=> AXI_BVALID_O && $stable(AXI_BRESP_O))
		else $error("write response dropped before bready");
	AST_RAM_WRITE: assert property (seq_write_pair ##0
		(reg_sel(s_reg.aw_addr) == SEL_RAM && s_reg.w_strb == 4'hf) |=>
		s_reg.ram[$past(s_reg.aw_addr[3:2])] == $past(s_reg.w_data))
		else $error("full word write did not reach display ram");
	AST_STEPUP: assert property (s_reg.cfg.drive_supply_select != STEPUP_EN_O
		|=> s_reg.cfg.drive_supply_select == STEPUP_EN_O || $changed(s_reg.cfg))
		else $error("step-up enable does not follow supply select");
	AST_CHARGE_NEVER: assert property (s_reg.cds == slcd_pkg::CDS_NEVER [*2]
		|-> !DIVIDER_CONNECT_O)
		else $error("divider connected with never setting");
	AST_CHARGE_ALWAYS: assert property (s_reg.cds == slcd_pkg::CDS_ALWAYS [*2]
		|-> DIVIDER_CONNECT_O)
		else $error("divider disconnected with always setting");
	AST_HALT_SUB: assert property (s_reg.only_s2 &&
		s_reg.cfg.frame_clock_select_field[slcd_pkg::CKS_SYS] |=> s_reg.halted &&
		SEG_EN_O == '0 && !POLARITY_O)
		else $error("display kept running on system clock in sub-clock mode");
	AST_SHADOW: assert property (!boundary |=> $stable(s_reg.sh_duty) && $stable(s_reg.sh_wave)
		&& $stable(s_reg.sh_sgs))
		else $error("configuration applied inside a frame");
	AST_STATIC_COM: assert property (s_reg.live && s_reg.lvl_duty == slcd_pkg::DUTY_STATIC
		&& $changed(POLARITY_O) |-> COM_LEVEL_O[0] == ($past(POLARITY_O) ?
		slcd_pkg::LVL_GND : slcd_pkg::LVL_FULL))
		else $error("static common level wrong for polarity");
	AST_POL_B: assert property (tick && frame_end && s_reg.sh_wave |=> POLARITY_O !=
		$past(POLARITY_O) && s_reg.slot == 2'h0)
		else $error("polarity did not flip at frame end");
endmodule

// *** tb/slcd_panel_model.sv ***
`timescale 1ns/10ps
module slcd_panel_model #(
	parameter int NSEG = 32
) (
	input wire logic clk_i,
	input wire logic clear_i,
	input wire slcd_pkg::slcd_level_t [slcd_pkg::NCOM-1:0] com_i,
	input wire slcd_pkg::slcd_level_t [NSEG-1:0] seg_i,
	input wire logic [NSEG-1:0] seg_en_i,
	output logic [slcd_pkg::NCOM-1:0][NSEG-1:0] lit_o
);
	// glass darkens only on a full swing; mid-level pairs stay clear
	always @(posedge clk_i) begin
		for (int c = 0; c < slcd_pkg::NCOM; c++) begin
			for (int i = 0; i < NSEG; i++) begin
				if (clear_i) begin
					lit_o[c][i] <= 1'b0;
				end else if (seg_en_i[i] && ({com_i[c], seg_i[i]} inside {4'hc, 4'h3})) begin
					lit_o[c][i] <= 1'b1;
				end
			end
		end
	end
endmodule

// *** tb/segment_lcd_drive_control_tb.sv ***
`timescale 1ns/10ps
module segment_lcd_drive_control_tb;
	logic clk, rst_b, sub_clk, sub_only, clr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, seg_en, rd;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid, pol, div, stepup, supply_on;
	logic [1:0] bresp, rresp, rs;
	slcd_pkg::slcd_level_t [slcd_pkg::NCOM-1:0] com_lvl;
	slcd_pkg::slcd_level_t [31:0] seg_lvl;
	logic [slcd_pkg::NCOM-1:0][31:0] lit;
	logic [31:0] ram [slcd_pkg::NCOM];
	int num_errors, samples_checked, cycles, sub_cnt;

	slcd_drive_ctrl dut_u (
		.CLOCK_I(clk),
		.RST_B_I(rst_b),
		.SUB_CLK_I(sub_clk),
		.SUB_CLOCK_ONLY_I(sub_only),
		.AXI_AWVALID_I(awvalid),
		.AXI_AWREADY_O(awready),
		.AXI_AWADDR_I(awaddr),
		.AXI_AWPROT_I(3'h0),
		.AXI_WVALID_I(wvalid),
		.AXI_WREADY_O(wready),
		.AXI_WDATA_I(wdata),
		.AXI_WSTRB_I(wstrb),
		.AXI_BVALID_O(bvalid),
		.AXI_BREADY_I(bready),
		.AXI_BRESP_O(bresp),
		.AXI_ARVALID_I(arvalid),
		.AXI_ARREADY_O(arready),
		.AXI_ARADDR_I(araddr),
		.AXI_ARPROT_I(3'h0),
		.AXI_RVALID_O(rvalid),
		.AXI_RREADY_I(rready),
		.AXI_RDATA_O(rdata),
		.AXI_RRESP_O(rresp),
		.COM_LEVEL_O(com_lvl),
		.SEG_LEVEL_O(seg_lvl),
		.SEG_EN_O(seg_en),
		.POLARITY_O(pol),
		.DIVIDER_CONNECT_O(div),
		.STEPUP_EN_O(stepup),
		.DRIVE_SUPPLY_ON_O(supply_on)
	);

	slcd_panel_model panel_u (
		.clk_i(clk),
		.clear_i(clr),
		.com_i(com_lvl),
		.seg_i(seg_lvl),
		.seg_en_i(seg_en),
		.lit_o(lit)
	);

	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end

	// sub clock rises every 18 cycles, phase unrelated to bus traffic
	always @(posedge clk) begin
		cycles <= cycles + 1;
		sub_cnt <= (sub_cnt == 8) ? 0 : sub_cnt + 1;
		if (sub_cnt == 8) begin
			sub_clk <= ~sub_clk;
		end
		if (cycles == 30000) begin
			num_errors++;
			close_out();
		end
	end

	task automatic close_out();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_on, w_on;
		@(posedge clk);
		aw_on = 1;
		w_on = 1;
		awvalid <= 1;
		awaddr <= a;
		wvalid <= 1;
		wdata <= d;
		wstrb <= s;
		bready <= 1;
		while (aw_on || w_on) begin
			@(posedge clk);
			if (aw_on && awready === 1'b1) begin
				aw_on = 0;
				awvalid <= 0;
			end
			if (w_on && wready === 1'b1) begin
				w_on = 0;
				wvalid <= 0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		rs = bresp;
		bready <= 0;
	endtask

	task automatic axr(input logic [7:0] a);
		@(posedge clk);
		arvalid <= 1;
		araddr <= a;
		rready <= 1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 0;
		while (rvalid !== 1'b1) @(posedge clk);
		rd = rdata;
		rs = rresp;
		rready <= 0;
	endtask

	// first pass lands on a toggle, the later passes time whole periods
	task automatic pol_period(output int n);
		logic p;
		for (int k = 0; k < 3; k++) begin
			p = pol;
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (pol === p);
		end
	endtask

	function automatic logic [31:0] exp_lit(input logic [31:0] w, input logic [3:0] sgs,
			input logic x);
		logic [31:0] e;
		for (int i = 0; i < 32; i++) begin
			e[i] = ((i / 4) <= sgs) && (x ? w[31-i] : w[i]);
		end
		return e;
	endfunction

	function automatic int exp_chg(input logic [3:0] c);
		if (c[3]) begin
			return c[2] ? 2 : 4;
		end
		if (c == 4'h7) begin
			return 0;
		end
		return (c == 4'h0) ? 64 : 8 * c;
	endfunction

	initial begin
		logic [31:0] c;
		int n;
		rst_b = 0;
		sub_clk = 0;
		sub_only = 0;
		clr = 1;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{num_errors, samples_checked, cycles, sub_cnt} = '0;
		void'($urandom(91));
		repeat (6) @(posedge clk);
		rst_b <= 1;
		axr(slcd_pkg::ADDR_CTRL);
		chk("ctrl reset", rd, 0);
		axr(slcd_pkg::ADDR_CHARGE);
		chk("charge reset", rd, 0);
		axw(8'h40, 32'hffffffff, 4'hf);
		chk("unmapped write resp", rs, slcd_pkg::RESP_SLVERR);
		axr(8'h40);
		chk("unmapped read resp", rs, slcd_pkg::RESP_SLVERR);
		for (int k = 0; k < 4; k++) begin
			axw(slcd_pkg::ADDR_CTRL, k << 11, 4'hf);
			repeat (2) @(posedge clk);
			chk("stepup enable", stepup, k & 1);
			chk("supply on", supply_on, k >> 1);
		end
		axw(slcd_pkg::ADDR_RAM0, 32'h11223344, 4'hf);
		axw(slcd_pkg::ADDR_RAM0, 32'haabbccdd, 4'h5);
		axr(slcd_pkg::ADDR_RAM0);
		chk("ram byte merge", rd, 32'h11bb33dd);
		for (int t = 0; t < 8; t++) begin
			c = $urandom & 32'h2400;
			c = c | (t % 4) | (($urandom % 16) << 2) | 32'h4200;
			rd = $urandom;
			for (int w = 0; w < 4; w++) begin
				ram[w] = (t % 4 == 0) ? rd : $urandom;
				axw(slcd_pkg::ADDR_RAM0 + 8'(4 * w), ram[w], 4'hf);
			end
			axw(slcd_pkg::ADDR_CTRL, c, 4'hf);
			repeat (40) @(posedge clk);
			clr <= 1;
			@(posedge clk);
			clr <= 0;
			repeat (120) @(posedge clk);
			for (int w = 0; w <= t % 4; w++) begin
				chk("lit pixels", lit[w], exp_lit(ram[w], c[5:2], c[13]));
			end
			chk("segment enables", seg_en, exp_lit('1, c[5:2], 1'b0));
		end
		for (int k = 0; k < 8; k++) begin
			axw(slcd_pkg::ADDR_CTRL, 32'h4003 | ((k & 1) << 10) | ((8 + k / 2) << 6), 4'hf);
			// the old waveform runs on to its frame end before the new one is loaded
			repeat (160) @(posedge clk);
			pol_period(n);
			chk("polarity period", n, ((k & 1) ? 4 : 1) << (k / 2 + 1));
		end
		sub_only <= 1;
		axw(slcd_pkg::ADDR_CTRL, 32'h4403, 4'hf);
		pol_period(n);
		chk("sub clock period", n, 72);
		axw(slcd_pkg::ADDR_CTRL, 32'h4603, 4'hf);
		repeat (200) @(posedge clk);
		chk("halted commons", com_lvl, 0);
		chk("halted enables", seg_en, 0);
		sub_only <= 0;
		for (int k = 0; k < 16; k++) begin
			axw(slcd_pkg::ADDR_CHARGE, k, 4'hf);
			repeat (3) @(posedge clk);
			n = 0;
			repeat (64) begin
				@(posedge clk);
				n += div;
			end
			chk("charge cycles", n, exp_chg(k));
		end
		close_out();
	end
endmodule
